// [ppei_interrupter.sv]
// event interrupter: merges three event sources onto one host interrupt
// assumes epp strobe, isaddr and send come from a synchronising handshaker
//
// How it works
// - three sources share one interrupt line
// - pulses start no faster than holdoff interval
// - pending events retrigger pulses until address-read
// - request sets pending flag until ack
// - pending and expired counter give two-cycle pulse
// - pulse start reloads holdoff counter
// - address-read presents unreported event mask
// - ack moves pending to reported, clears pending
// - request while pending is dropped
// - ack loads pending from current request
// - scan start issues repeated calibration requests
// - next calibration request waits for host entry
// - exhausted calibration entry discarded, replacement requested
// - integration boundary raises integration request
// - pps request in the cycle of the synchronised edge, two cycles after pps_in edge
// - no own interrupt enable or mask
// - isaddr marks address cycle, send marks read
// - handshaker strobe lasts at most one cycle
//
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
module ppei_interrupter
#(
   parameter int CNT_W = 16,
   parameter logic [15:0] HOLDOFF_INIT = ppei_pkg::HOLDOFF_RESET,
   parameter logic [7:0] CAL_FILL = ppei_pkg::CAL_FILL_RESET
)
(
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // epp handshaker indications
   input wire logic epp_strobe,
   input wire logic epp_isaddr,
   input wire logic epp_send,
   output logic [7:0] epp_data_out,
   output logic intr,
   // event sources
   input wire logic scan_start,
   input wire logic cal_entry_written,
   input wire logic cal_exhausted,
   output logic cal_discard,
   input wire logic integ_boundary,
   input wire logic pps_in
);

   // holdoff interval register, software writable
   logic [15:0] holdoff;
   // holdoff down-counter
   logic [CNT_W-1:0] holdoff_cnt;
   // remaining high cycles of the interrupt pulse
   logic [1:0] pulse_left;
   // per-source latches
   logic [ppei_pkg::NUM_SRC-1:0] pending;
   logic [ppei_pkg::NUM_SRC-1:0] reported;
   // request pulses into the latch bank
   logic [ppei_pkg::NUM_SRC-1:0] req;
   logic cal_req;
   logic int_req;
   logic sec_req;
   // pps synchroniser and edge stage
   logic pps_meta;
   logic pps_sync;
   logic pps_prev;
   // calibration sequencer
   ppei_pkg::ppei_cal_e cal_state;
   logic [7:0] fill_left;
   logic refill_due;
   // axi bookkeeping
   logic aw_hold;
   logic w_hold;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   // true when the byte address names a register
   function automatic logic is_reg(input logic [7:0] a);
      is_reg = (a == ppei_pkg::ADDR_HOLDOFF) ||
               (a == ppei_pkg::ADDR_STATUS);
   endfunction : is_reg

   // byte-lane merge of write data into the old value
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] d,
                                           input logic [3:0] s);
      merge16 = old;
      if (s[0])
         merge16[7:0] = d[7:0];
      if (s[1])
         merge16[15:8] = d[15:8];
   endfunction : merge16

   wire ack = epp_strobe & epp_isaddr & epp_send;

   wire any_pending = |pending;

   wire pulse_start = any_pending && (holdoff_cnt == '0);

   // reload value, never shorter than the pulse itself
   wire [CNT_W-1:0] reload_val =
      (holdoff < 16'(ppei_pkg::INTR_PULSE_CYCLES)) ?
      CNT_W'(ppei_pkg::INTR_PULSE_CYCLES) : CNT_W'(holdoff);

   assign req[ppei_pkg::SRC_CAL] = cal_req;
   assign req[ppei_pkg::SRC_INT] = int_req;
   assign req[ppei_pkg::SRC_SEC] = sec_req;

   // pending and reported latch pairs
   ppei_irq_bank #(.N(ppei_pkg::NUM_SRC)) u_bank
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .req(req),
      .ack(ack),
      .pending_latch(pending),
      .reported_latch(reported)
   );

   // bits 0 to 2, rest zero
   assign epp_data_out = {5'h0, reported};

   // holdoff counter
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         holdoff_cnt <= '0;
      else if (pulse_start)
         holdoff_cnt <= reload_val;
      else if (holdoff_cnt != '0)
         holdoff_cnt <= holdoff_cnt - 1'b1;
   end

   // interrupt pulse generator
   // no enable gating here
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pulse_left <= 2'h0;
         intr <= 1'b0;
      end
      else if (pulse_start)
      begin
         pulse_left <= ppei_pkg::INTR_PULSE_CYCLES - 2'h1;
         intr <= 1'b1;
      end
      else if (pulse_left != 2'h0)
      begin
         pulse_left <= pulse_left - 2'h1;
         intr <= 1'b1;
      end
      else
         intr <= 1'b0;
   end

   // pps synchroniser, first stage read only by the second
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pps_meta <= 1'b0;
         pps_sync <= 1'b0;
         pps_prev <= 1'b0;
      end
      else
      begin
         pps_meta <= pps_in;
         pps_sync <= pps_meta;
         pps_prev <= pps_sync;
      end
   end

   assign sec_req = pps_sync & ~pps_prev;

   assign int_req = integ_boundary;

   // calibration request when not awaiting an answer
   // wait for host entry
   wire cal_fire = (cal_state == ppei_pkg::CAL_IDLE) &&
                   ((fill_left != 8'h0) || refill_due);
   assign cal_req = cal_fire;

   // calibration request sequencer
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cal_state <= ppei_pkg::CAL_IDLE;
         fill_left <= 8'h0;
         refill_due <= 1'b0;
         cal_discard <= 1'b0;
      end
      else
      begin
         cal_discard <= cal_exhausted;
         case (cal_state)
            ppei_pkg::CAL_IDLE:
            begin
               if (cal_fire)
                  cal_state <= ppei_pkg::CAL_WAIT;
            end
            ppei_pkg::CAL_WAIT:
            begin
               // host answered with a new entry
               if (cal_entry_written)
                  cal_state <= ppei_pkg::CAL_IDLE;
            end
            default:
               cal_state <= ppei_pkg::CAL_IDLE;
         endcase
         if (scan_start)
            fill_left <= CAL_FILL;
         else if (cal_fire && fill_left != 8'h0)
            fill_left <= fill_left - 8'h1;
         if (cal_exhausted)
            refill_due <= 1'b1;
         else if (cal_fire && fill_left == 8'h0)
            refill_due <= 1'b0;
      end
   end

   // axi write handshake terms
   wire aw_take = s_axi_awvalid & s_axi_awready;
   wire w_take = s_axi_wvalid & s_axi_wready;
   wire wr_fire = aw_hold & w_hold & ~s_axi_bvalid;
   wire next_aw_hold = aw_take | (aw_hold & ~wr_fire);
   wire next_w_hold = w_take | (w_hold & ~wr_fire);

   // axi write address and data capture
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_hold <= 1'b0;
         w_hold <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         aw_addr <= 8'h0;
         w_data <= 32'h0;
         w_strb <= 4'h0;
      end
      else
      begin
         aw_hold <= next_aw_hold;
         w_hold <= next_w_hold;
         s_axi_awready <= ~next_aw_hold;
         s_axi_wready <= ~next_w_hold;
         if (aw_take)
            aw_addr <= s_axi_awaddr;
         if (w_take)
         begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
      end
   end

   // axi write response and holdoff register
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= ppei_pkg::RESP_OKAY;
         holdoff <= HOLDOFF_INIT;
      end
      else if (wr_fire)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= is_reg(aw_addr) ? ppei_pkg::RESP_OKAY :
                        ppei_pkg::RESP_DECERR;
         if (aw_addr == ppei_pkg::ADDR_HOLDOFF)
            holdoff <= merge16(holdoff, w_data, w_strb);
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // status word showing the block's own state
   wire [31:0] status_word =
      (32'(pending) << ppei_pkg::STAT_PEND_LSB) |
      (32'(reported) << ppei_pkg::STAT_REP_LSB) |
      (32'(intr) << ppei_pkg::STAT_INTR_BIT) |
      (32'(cal_state == ppei_pkg::CAL_WAIT) <<
       ppei_pkg::STAT_CALWAIT_BIT);

   // read data selection
   wire [31:0] rd_word =
      (s_axi_araddr == ppei_pkg::ADDR_HOLDOFF) ? {16'h0, holdoff} :
      (s_axi_araddr == ppei_pkg::ADDR_STATUS) ? status_word : 32'h0;

   // axi read channel
   wire ar_take = s_axi_arvalid & s_axi_arready;
   wire next_rvalid = ar_take | (s_axi_rvalid & ~s_axi_rready);

   // read address take and data answer
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= ppei_pkg::RESP_OKAY;
      end
      else
      begin
         s_axi_rvalid <= next_rvalid;
         s_axi_arready <= ~next_rvalid;
         if (ar_take)
         begin
            s_axi_rdata <= rd_word;
            s_axi_rresp <= is_reg(s_axi_araddr) ? ppei_pkg::RESP_OKAY :
                           ppei_pkg::RESP_DECERR;
         end
      end
   end

endmodule : ppei_interrupter

// [ppei_pkg.sv]
// shared constants for the parallel-port event interrupter
// assumes a single 250 MHz clock and an AXI4-Lite register bus
package ppei_pkg;

   // event source bit positions in the returned mask
   localparam int SRC_CAL = 0;
   localparam int SRC_INT = 1;
   localparam int SRC_SEC = 2;
   localparam int NUM_SRC = 3;

   // register byte offsets
   localparam logic [7:0] ADDR_HOLDOFF = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;

   // status register field positions
   localparam int STAT_PEND_LSB = 0;
   localparam int STAT_REP_LSB = 4;
   localparam int STAT_INTR_BIT = 8;
   localparam int STAT_CALWAIT_BIT = 9;

   // reset values
   localparam logic [15:0] HOLDOFF_RESET = 16'h0100;
   localparam logic [7:0] CAL_FILL_RESET = 8'h08;

   // interrupt line pulse length in clock cycles
   localparam logic [1:0] INTR_PULSE_CYCLES = 2'h2;

   // axi response codes
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   // calibration request sequencer states
   typedef enum logic [0:0]
   {
      CAL_IDLE = 1'b0,
      CAL_WAIT = 1'b1
   } ppei_cal_e;

endpackage : ppei_pkg

// [ppei_irq_bank.sv]
// a bank of two-stage request/report latch pairs, one per event source
// assumes requests are single-cycle pulses synchronous to aclk
module ppei_irq_bank
#(
   parameter int N = 3
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [N-1:0] req,
   input wire logic ack,
   output logic [N-1:0] pending_latch,
   output logic [N-1:0] reported_latch
);

   // request capture and acknowledge transfer
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pending_latch <= '0;
         reported_latch <= '0;
      end
      else if (ack)
      begin
         reported_latch <= pending_latch;
         pending_latch <= req;
      end
      else
      begin
         pending_latch <= pending_latch | req;
      end
   end

endmodule : ppei_irq_bank

// [ppei_interrupter_assertions.sv]
// assertion checker for the event interrupter, bound to its ports
// assumes one clock domain and a synchronous active-low reset
module ppei_interrupter_chk
#(
   parameter logic [15:0] HOLD = 16'h0008
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic intr,
   input wire logic epp_strobe,
   input wire logic epp_isaddr,
   input wire logic epp_send,
   input wire logic [7:0] epp_data_out,
   input wire logic integ_boundary,
   input wire logic pps_in,
   input wire logic cal_exhausted,
   input wire logic cal_discard,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid
);
   timeunit 1ns;
   timeprecision 1ps;
   // host address-read acknowledge
   wire ack = epp_strobe & epp_isaddr & epp_send;
   // pps synchroniser copy, pending copy of sources 1 and 2
   logic [2:0] sy;
   logic [2:1] pm;
   // previous intr, cycles since the last pulse start
   logic iq;
   logic [15:0] since;
   wire [2:1] rq = {sy[1] & ~sy[2], integ_boundary};
   wire [15:0] next_since = (intr & ~iq) ? 16'h0001 : since + {15'h0, ~&since};
   // reference latches and pulse spacing counter
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sy <= 3'h0;
         pm <= 2'h0;
         iq <= 1'h0;
         since <= 16'hffff;
      end
      else
      begin
         sy <= {sy[1:0], pps_in};
         pm <= ack ? rq : (pm | rq);
         iq <= intr;
         since <= next_since;
      end
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_pulse_two: assert property ($rose(intr) |=> intr ##1 !intr)
      else $error("intr pulse is not two cycles");
   a_pulse_space: assert property (intr && !iq |-> since > HOLD)
      else $error("intr pulses too close");
   a_retry_due: assert property (
      (pm != 2'h0) [*3] |-> since <= HOLD + 16'h2)
      else $error("pending event not retried");
   a_mask_report: assert property (
      ack |=> epp_data_out[2:1] == $past(pm))
      else $error("mask does not show pending events");
   a_mask_upper: assert property (epp_data_out[7:3] == 5'h0)
      else $error("unused mask bits not zero");
   a_mask_stable: assert property (!ack |=> $stable(epp_data_out))
      else $error("mask changed without address-read");
   a_discard_echo: assert property (cal_exhausted |=> cal_discard)
      else $error("exhausted entry not discarded");
   a_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
endmodule : ppei_interrupter_chk

bind ppei_interrupter ppei_interrupter_chk #(.HOLD(HOLDOFF_INIT)) u_chk (.*);

// [ppei_host_epp.sv]
// host side of the epp link as seen after the strobe synchroniser
// assumes go is a one-cycle request; rd picks read or write
module ppei_host_epp
(
   input wire logic aclk,
   input wire logic go,
   input wire logic rd,
   output logic epp_strobe,
   output logic epp_isaddr,
   output logic epp_send
);
   timeunit 1ns;
   timeprecision 1ps;
   // 1 while qualifiers settle, 2 while strobing
   logic [1:0] ph;
   initial
   begin
      ph = 2'h0;
      epp_strobe = 1'h0;
      epp_isaddr = 1'h0;
      epp_send = 1'h0;
   end
   // qualifiers a cycle early, one-cycle strobe
   always @(posedge aclk)
   begin
      ph <= go ? 2'h1 : {1'h0, ph == 2'h1} << 1;
      epp_isaddr <= go | (ph == 2'h1);
      epp_send <= (go | (ph == 2'h1)) & rd;
      epp_strobe <= ph == 2'h1;
   end
endmodule : ppei_host_epp

// [tb_top.sv]
// self-checking bench for the event interrupter
// assumes a 250 MHz clock and the host model on the epp side
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] HOLD = 16'h0008;
   localparam logic [7:0] AH = ppei_pkg::ADDR_HOLDOFF;
   localparam logic [7:0] AS = ppei_pkg::ADDR_STATUS;
   localparam logic [1:0] OK = ppei_pkg::RESP_OKAY;
   localparam logic [1:0] DE = ppei_pkg::RESP_DECERR;
   // status with the cal flag reported and the sequencer awaiting an entry
   localparam logic [31:0] ST = (32'h1 << ppei_pkg::STAT_REP_LSB) |
      (32'h1 << ppei_pkg::STAT_CALWAIT_BIT);
   typedef struct packed
   {
      logic w;
      logic [7:0] a;
      logic [31:0] d;
      logic [1:0] r;
   } ppei_row_s;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready, epp_strobe, epp_isaddr;
   logic epp_send, intr, scan_start, cal_entry_written, cal_exhausted;
   logic cal_discard, integ_boundary, pps_in, go, rd;
   logic [7:0] s_axi_awaddr, s_axi_araddr, epp_data_out;
   logic [31:0] s_axi_wdata, s_axi_rdata, q;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   int num_errors, tests_run, cyc, n;
   int rises[$];
   // register accesses: write or read, address, data, response
   ppei_row_s rows [8] = '{'{1'h0, AH, 32'h8, OK}, '{1'h1, AH, 32'hc, OK},
      '{1'h0, AH, 32'hc, OK}, '{1'h1, AH, 32'h8, OK}, '{1'h1, AS, 32'hff, OK},
      '{1'h0, AS, 32'h0, OK}, '{1'h1, 8'h10, 32'h5, DE},
      '{1'h0, 8'h10, 32'h0, DE}};
   ppei_interrupter #(.HOLDOFF_INIT(HOLD), .CAL_FILL(8'h02)) uut (.*);
   ppei_host_epp host (.*);
   always #2 aclk = ~aclk;
   // cycle count, intr pulse starts, hang guard
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if ($rose(intr)) rises.push_back(cyc);
      if (cyc == 5000)
      begin
         num_errors++;
         report_and_stop();
      end
   end
   task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      tests_run++;
      if (s !== e)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   // one axi4-lite write or read, each channel released when taken
   task ax(input ppei_row_s x);
      @(posedge aclk);
      s_axi_awaddr <= x.a;
      s_axi_araddr <= x.a;
      s_axi_wdata <= x.d;
      s_axi_awvalid <= x.w;
      s_axi_wvalid <= x.w;
      s_axi_bready <= x.w;
      s_axi_arvalid <= !x.w;
      s_axi_rready <= !x.w;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end
      while (!(x.w ? s_axi_bvalid : s_axi_rvalid));
      q = s_axi_rdata;
      r = x.w ? s_axi_bresp : s_axi_rresp;
      s_axi_bready <= 1'h0;
      s_axi_rready <= 1'h0;
   endtask : ax
   // host address cycle, then the mask on the data lines
   task ack(input logic [7:0] e, input string nm);
      go <= 1'h1;
      @(posedge aclk);
      go <= 1'h0;
      repeat (5) @(posedge aclk);
      chk(nm, {24'h0, e}, {24'h0, epp_data_out});
   endtask : ack
   task report_and_stop();
      $display("checks %0d errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : report_and_stop
   initial
   begin
      {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h0;
      {s_axi_arvalid, s_axi_rready, scan_start, cal_entry_written} = 4'h0;
      {cal_exhausted, integ_boundary, pps_in, go, rd} = 5'h1;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hf;
      repeat (5) @(posedge aclk);
      aresetn <= 1'h1;
      foreach (rows[i])
      begin
         ax(rows[i]);
         chk("resp", {30'h0, rows[i].r}, {30'h0, r});
         if (!rows[i].w) chk("rdata", rows[i].d, q);
      end
      // one-cycle event, then retries every holdoff + 1
      integ_boundary <= 1'h1;
      @(posedge aclk);
      integ_boundary <= 1'h0;
      repeat (25) @(posedge aclk);
      chk("retry period", 32'h9, rises[1] - rises[0]);
      integ_boundary <= 1'h1;
      @(posedge aclk);
      integ_boundary <= 1'h0;
      rd <= 1'h0;
      ack(8'h00, "epp write mask");
      rd <= 1'h1;
      ack(8'h02, "integ mask");
      n = rises.size();
      repeat (30) @(posedge aclk);
      chk("no retry", n, rises.size());
      ack(8'h00, "dropped request");
      // request coinciding with the acknowledge strobe is kept
      go <= 1'h1;
      @(posedge aclk);
      go <= 1'h0;
      @(posedge aclk);
      integ_boundary <= 1'h1;
      @(posedge aclk);
      integ_boundary <= 1'h0;
      ack(8'h02, "coincident request");
      pps_in <= 1'h1;
      repeat (6) @(posedge aclk);
      pps_in <= 1'h0;
      ack(8'h04, "pps mask");
      // calibration fill of two, wait for entries, refill
      scan_start <= 1'h1;
      @(posedge aclk);
      scan_start <= 1'h0;
      ack(8'h01, "first cal");
      ack(8'h00, "cal waits");
      cal_entry_written <= 1'h1;
      @(posedge aclk);
      cal_entry_written <= 1'h0;
      ack(8'h01, "second cal");
      cal_entry_written <= 1'h1;
      @(posedge aclk);
      cal_entry_written <= 1'h0;
      ack(8'h00, "fill done");
      cal_exhausted <= 1'h1;
      @(posedge aclk);
      cal_exhausted <= 1'h0;
      ack(8'h01, "refill cal");
      // status fields, then a mid-run reset must clear latches and restore holdoff
      ax('{1'h1, AH, 32'hc, OK});
      chk("holdoff write resp", {30'h0, OK}, {30'h0, r});
      ax('{1'h0, AS, 32'h0, OK});
      chk("status before reset", ST, q);
      aresetn <= 1'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      chk("intr after reset", 32'h0, {31'h0, intr});
      chk("mask after reset", 32'h0, {24'h0, epp_data_out});
      ax('{1'h0, AH, 32'h0, OK});
      chk("holdoff after reset", {16'h0, HOLD}, q);
      ax('{1'h0, AS, 32'h0, OK});
      chk("status after reset", 32'h0, q);
      report_and_stop();
   end
endmodule : tb_top
